// ==== logic/abx_pkg.sv ====
// Constants, types and register map of the AND/branch/bit-clear executor
package abx_pkg;
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] OFF_OPCODE = 8'h00;
    localparam logic [AXI_AW-1:0] OFF_WREG = 8'h04;
    localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h08;
    localparam logic [AXI_AW-1:0] OFF_BANK = 8'h0c;
    localparam logic [AXI_AW-1:0] OFF_PC = 8'h10;
    localparam logic [AXI_AW-1:0] OFF_EXEC = 8'h14;
    localparam logic [AXI_AW-1:0] OFF_FADDR = 8'h18;
    localparam logic [AXI_AW-1:0] OFF_FDATA = 8'h1c;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Opcode patterns
    localparam logic [5:0] OPC_AND_WF = 6'h05;
    localparam logic [7:0] OPC_BR_CARRY = 8'he2;
    localparam logic [7:0] OPC_BR_NEG = 8'he6;
    localparam logic [3:0] OPC_BIT_CLR = 4'h9;

    // Opcode field positions
    localparam int FLD_DEST = 9;
    localparam int FLD_ACC = 8;
    localparam int FLD_BIT_HI = 11;
    localparam int FLD_BIT_LO = 9;

    // Status register bit positions
    localparam int ST_C = 0;
    localparam int ST_Z = 2;
    localparam int ST_N = 4;

    // Exec register bit positions
    localparam int EX_BUSY = 0;
    localparam int EX_ILL = 1;
    localparam int EX_CYC_LO = 4;

    localparam logic [7:0] ACC_SPLIT_BIT = 8'h80;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [1:0] NOP_PHASES = 2'h3;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    typedef enum logic [2:0] {
        PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4, PH_NOP
    } abx_phase_t;

    typedef enum logic [2:0] {
        OP_NONE, OP_AND_WF, OP_BR_CARRY, OP_BR_NEG, OP_BIT_CLR
    } abx_op_t;
endpackage

// ==== logic/abx_decode.sv ====
// Opcode decoder and data path for the executor
`timescale 1ns/1ps
`default_nettype none
module abx_decode #(
    parameter int PC_W = 16
) (
    input wire logic [15:0] opcode,
    input wire logic [7:0] wreg,
    input wire logic [7:0] fval,
    input wire logic [PC_W-1:0] pc_inc,
    input wire logic flag_c,
    input wire logic flag_n,
    output abx_pkg::abx_op_t op,
    output logic dest_file,
    output logic acc_bank,
    output logic [7:0] faddr,
    output logic [7:0] result,
    output logic taken,
    output logic [PC_W-1:0] target
);
    import abx_pkg::*;

    wire is_and = opcode[15:10] == OPC_AND_WF;
    wire is_bc = opcode[15:8] == OPC_BR_CARRY;
    wire is_bn = opcode[15:8] == OPC_BR_NEG;
    wire is_bcf = opcode[15:12] == OPC_BIT_CLR;
    wire [7:0] offset = opcode[7:0];
    wire [2:0] bit_idx = opcode[FLD_BIT_HI:FLD_BIT_LO];
    wire [7:0] clr_mask = ~(8'h01 << bit_idx);
    wire [PC_W-1:0] disp = {{(PC_W-9){offset[7]}}, offset, 1'b0};

    assign op = is_and ? OP_AND_WF :
                is_bc ? OP_BR_CARRY :
                is_bn ? OP_BR_NEG :
                is_bcf ? OP_BIT_CLR : OP_NONE;
    assign dest_file = is_and & opcode[FLD_DEST];
    assign acc_bank = ~opcode[FLD_ACC];
    assign faddr = opcode[7:0];
    assign result = is_and ? (wreg & fval) :
                    (fval & clr_mask);
    assign taken = (is_bc & flag_c) | (is_bn & flag_n);
    assign target = pc_inc + disp;
endmodule
`default_nettype wire

// ==== logic/abx_exec.sv ====
// AXI4-Lite wrapped executor for AND, carry/negative branches, bit clear
`timescale 1ns/1ps
`default_nettype none
module abx_exec #(
    parameter int PC_W = 16,
    parameter int BANK_W = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [abx_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [abx_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import abx_pkg::*;

    localparam int FI_W = BANK_W + 8;
    localparam int DEPTH = 1 << FI_W;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Write and read channel holding registers
    logic aw_full_q;
    logic [AXI_AW-1:0] aw_addr_q;
    logic w_full_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // Core state
    abx_phase_t phase_q;
    logic [1:0] nop_cnt_q;
    logic [15:0] op_q;
    logic [7:0] wreg_q;
    logic [7:0] status_q;
    logic [BANK_W-1:0] bank_q;
    logic [PC_W-1:0] pc_q;
    logic [7:0] fval_q;
    logic [7:0] res_q;
    logic ill_q;
    logic [1:0] cyc_q;
    logic [FI_W-1:0] win_q;
    logic [7:0] mem_q [DEPTH];

    abx_op_t dec_op;
    logic dec_dest_file;
    logic dec_acc;
    logic [7:0] dec_faddr;
    logic [7:0] dec_result;
    logic dec_taken;
    logic [PC_W-1:0] dec_target;

    abx_decode #(.PC_W(PC_W)) u_decode (
        .opcode(op_q),
        .wreg(wreg_q),
        .fval(fval_q),
        .pc_inc(pc_q),
        .flag_c(status_q[ST_C]),
        .flag_n(status_q[ST_N]),
        .op(dec_op),
        .dest_file(dec_dest_file),
        .acc_bank(dec_acc),
        .faddr(dec_faddr),
        .result(dec_result),
        .taken(dec_taken),
        .target(dec_target)
    );

    // Bus decode
    wire busy = phase_q != PH_IDLE;
    wire wr_fire = aw_full_q & w_full_q & ~bvalid_q & ~busy;
    wire ar_fire = s_axi_arvalid & ~rvalid_q;
    wire [31:0] wmerge_base = 32'h0000_0000;
    wire [31:0] wval = merge(wmerge_base, w_data_q, w_strb_q);
    wire wr_opcode = wr_fire & (aw_addr_q == OFF_OPCODE);
    wire wr_wreg = wr_fire & (aw_addr_q == OFF_WREG) & w_strb_q[0];
    wire wr_status = wr_fire & (aw_addr_q == OFF_STATUS) & w_strb_q[0];
    wire wr_bank = wr_fire & (aw_addr_q == OFF_BANK) & w_strb_q[0];
    wire wr_pc = wr_fire & (aw_addr_q == OFF_PC);
    wire wr_exec = wr_fire & (aw_addr_q == OFF_EXEC) & w_strb_q[0];
    wire wr_faddr = wr_fire & (aw_addr_q == OFF_FADDR);
    wire wr_fdata = wr_fire & (aw_addr_q == OFF_FDATA) & w_strb_q[0];
    wire wr_hit = (aw_addr_q[AXI_AW-1:5] == '0) & (aw_addr_q[1:0] == 2'h0);
    wire rd_hit = (s_axi_araddr[AXI_AW-1:5] == '0)
                & (s_axi_araddr[1:0] == 2'h0);
    wire [31:0] pc_merged = merge({{(32-PC_W){1'b0}}, pc_q}, w_data_q,
                                  w_strb_q);
    wire [31:0] win_merged = merge({{(32-FI_W){1'b0}}, win_q}, w_data_q,
                                   w_strb_q);
    wire [31:0] op_merged = merge({16'h0000, op_q}, w_data_q, w_strb_q);
    wire [7:0] exec_rd = {2'h0, cyc_q, 2'h0, ill_q, busy};

    // Read data selection
    wire [31:0] rd_mux =
        (s_axi_araddr == OFF_OPCODE) ? {16'h0000, op_q} :
        (s_axi_araddr == OFF_WREG) ? {24'h000000, wreg_q} :
        (s_axi_araddr == OFF_STATUS) ? {24'h000000, status_q} :
        (s_axi_araddr == OFF_BANK) ? {{(32-BANK_W){1'b0}}, bank_q} :
        (s_axi_araddr == OFF_PC) ? {{(32-PC_W){1'b0}}, pc_q} :
        (s_axi_araddr == OFF_EXEC) ? {24'h000000, exec_rd} :
        (s_axi_araddr == OFF_FADDR) ? {{(32-FI_W){1'b0}}, win_q} :
        (s_axi_araddr == OFF_FDATA) ? {24'h000000, mem_q[win_q]} :
        32'h0000_0000;

    // File address: access bank splits at bit 7 of the operand
    wire [BANK_W-1:0] acc_bank_no = dec_faddr[7] ? '1 : '0;
    wire [BANK_W-1:0] bank_sel = dec_acc ? acc_bank_no : bank_q;
    wire [FI_W-1:0] file_idx = {bank_sel, dec_faddr};

    wire in_q4 = phase_q == PH_Q4;
    wire file_op = (dec_op == OP_AND_WF) | (dec_op == OP_BIT_CLR);
    wire is_branch = (dec_op == OP_BR_CARRY) | (dec_op == OP_BR_NEG);
    wire ex_mem_we = in_q4 & ((dec_op == OP_BIT_CLR) | dec_dest_file);
    wire ex_wreg_we = in_q4 & (dec_op == OP_AND_WF) & ~dec_dest_file;
    wire and_done = in_q4 & (dec_op == OP_AND_WF);
    wire br_jump = in_q4 & is_branch & dec_taken;
    wire mem_we = ex_mem_we | wr_fdata;
    wire [FI_W-1:0] mem_idx = ex_mem_we ? file_idx : win_q;
    wire [7:0] mem_wdata = ex_mem_we ? res_q : w_data_q[7:0];

    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready = ~w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid & ~aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid & ~w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rd_mux;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Four-phase sequencer, plus four no-op phases (PH_NOP) after a taken branch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= PH_IDLE;
            nop_cnt_q <= '0;
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    if (wr_opcode) begin
                        phase_q <= PH_Q1;
                    end
                end
                PH_Q1: phase_q <= PH_Q2;
                PH_Q2: phase_q <= PH_Q3;
                PH_Q3: phase_q <= PH_Q4;
                PH_Q4: begin
                    if (br_jump) begin
                        phase_q <= PH_NOP;
                        nop_cnt_q <= NOP_PHASES;
                    end else begin
                        phase_q <= PH_IDLE;
                    end
                end
                PH_NOP: begin
                    if (nop_cnt_q == 2'h0) begin
                        phase_q <= PH_IDLE;
                    end
                    nop_cnt_q <= nop_cnt_q - 2'h1;
                end
                default: phase_q <= PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_q <= '0;
        end else if (wr_opcode) begin
            op_q <= op_merged[15:0];
        end
    end

    // Q2 reads the file operand, Q3 forms the result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fval_q <= '0;
            res_q <= '0;
        end else begin
            if (phase_q == PH_Q2 && file_op) begin
                fval_q <= mem_q[file_idx];
            end
            if (phase_q == PH_Q3) begin
                res_q <= dec_result;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreg_q <= WREG_RST;
        end else if (ex_wreg_we) begin
            wreg_q <= res_q;
        end else if (wr_wreg) begin
            wreg_q <= wval[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= STATUS_RST;
        end else if (and_done) begin
            status_q[ST_N] <= res_q[7];
            status_q[ST_Z] <= res_q == 8'h00;
        end else if (wr_status) begin
            status_q <= wval[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_q <= '0;
        end else if (wr_bank) begin
            bank_q <= wval[BANK_W-1:0];
        end
    end

    // PC steps by one word in Q1; a taken branch overwrites it in Q4
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_q <= '0;
        end else if (phase_q == PH_Q1) begin
            pc_q <= pc_q + PC_W'(2);
        end else if (br_jump) begin
            pc_q <= dec_target;
        end else if (wr_pc) begin
            pc_q <= pc_merged[PC_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ill_q <= 1'b0;
            cyc_q <= '0;
        end else if (in_q4) begin
            ill_q <= dec_op == OP_NONE;
            cyc_q <= br_jump ? CYC_TWO : CYC_ONE;
        end else if (wr_exec && w_data_q[EX_ILL]) begin
            ill_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_q <= '0;
        end else if (wr_faddr) begin
            win_q <= win_merged[FI_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem_q[mem_idx] <= mem_wdata;
        end
    end
endmodule
`default_nettype wire

// ==== tb/abx_exec_props.sv ====
// Bus protocol and execution timing checks for the executor
`timescale 1ns/1ps
`default_nettype none
module abx_exec_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [abx_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [abx_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import abx_pkg::*;
    logic [AXI_AW-1:0] wa_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wa_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            wa_q <= s_axi_awaddr;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_wr_busy: assert property ($rose(s_axi_bvalid) |->
        !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("write answered early");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready |->
        ##[1:20] s_axi_bvalid) else $error("write answer missing");
    a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("write answer repeated");
    a_bad_addr: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > 8'h1c |=> s_axi_rresp == RESP_SLVERR &&
        s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    a_exec_stall: assert property (s_axi_bvalid && s_axi_bready &&
        wa_q == OFF_OPCODE |=> !s_axi_bvalid [*4])
        else $error("write finished during instruction");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_error: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// ==== tb/abx_axi_master.sv ====
// Register bus master standing in for the surrounding core
`timescale 1ns/1ps
`default_nettype none
module abx_axi_master (
    input wire logic aclk,
    output var logic [abx_pkg::AXI_AW-1:0] s_axi_awaddr,
    output var logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output var logic [31:0] s_axi_wdata,
    output var logic [3:0] s_axi_wstrb,
    output var logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output var logic s_axi_bready,
    output var logic [abx_pkg::AXI_AW-1:0] s_axi_araddr,
    output var logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output var logic s_axi_rready
);
    import abx_pkg::*;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    // Handshakes judged at the rising edge; bready and rready stay high
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ad, wd, b;
        ad = 1'b0;
        wd = 1'b0;
        b = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            b = s_axi_bvalid;
            r = s_axi_bresp;
            if (!ad && s_axi_awready) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (!wd && s_axi_wready) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
    endtask
    task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ad, v;
        ad = 1'b0;
        v = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!v) begin
            @(posedge aclk);
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (!ad && s_axi_arready) begin
                ad = 1'b1;
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/test_abx_exec.sv ====
// Self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
module test_abx_exec;
    import abx_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int last_dt;
    always #2.5 aclk = ~aclk;
    abx_exec #(.PC_W(16), .BANK_W(2)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    abx_axi_master m (.aclk(aclk), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic w(input logic [AXI_AW-1:0] a, input logic [31:0] d);
        logic [1:0] r;
        m.wr(a, d, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask
    task automatic rc(input logic [AXI_AW-1:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        m.rd(a, d, r);
        chk(d, e);
    endtask
    // Second write stalls until the instruction has retired
    task automatic run(input logic [15:0] op, input logic [31:0] bk);
        int t0;
        w(OFF_OPCODE, {16'h0, op});
        t0 = cyc;
        w(OFF_BANK, bk);
        last_dt = cyc - t0;
    endtask
    task automatic t_reset;
        rc(OFF_WREG, 32'h0);
        rc(OFF_STATUS, 32'h0);
        rc(OFF_PC, 32'h0);
        rc(OFF_EXEC, 32'h0);
    endtask
    task automatic t_and;
        w(OFF_BANK, 32'h1);
        w(OFF_FADDR, 32'h123);
        w(OFF_FDATA, 32'hc2);
        w(OFF_WREG, 32'h28);
        w(OFF_STATUS, 32'h11);
        run(16'h1523, 32'h1);
        rc(OFF_WREG, 32'h00);
        rc(OFF_STATUS, 32'h05);
        rc(OFF_FDATA, 32'hc2);
        w(OFF_FADDR, 32'h390);
        w(OFF_FDATA, 32'hf0);
        w(OFF_WREG, 32'h8f);
        run(16'h1690, 32'h1);
        rc(OFF_FDATA, 32'h80);
        rc(OFF_WREG, 32'h8f);
        rc(OFF_STATUS, 32'h11);
    endtask
    task automatic t_branch;
        logic [15:0] ops[4] = '{16'he280, 16'he27f, 16'he67f, 16'he680};
        logic [7:0] st[4] = '{8'h01, 8'h10, 8'h10, 8'h01};
        logic [15:0] pc;
        logic [31:0] d;
        logic [1:0] r;
        int dt[4];
        for (int i = 0; i < 4; i++) begin
            w(OFF_PC, 32'h1000);
            w(OFF_STATUS, {24'h0, st[i]});
            run(ops[i], 32'h1);
            dt[i] = last_dt;
            pc = 16'h1002;
            if (i % 2 == 0) begin
                pc = pc + {{7{ops[i][7]}}, ops[i][7:0], 1'b0};
            end
            rc(OFF_PC, {16'h0, pc});
            rc(OFF_STATUS, {24'h0, st[i]});
            m.rd(OFF_EXEC, d, r);
            chk({30'h0, d[5:4]}, (i % 2 == 0) ? 32'h2 : 32'h1);
        end
        chk(32'(dt[0] - dt[1]), 32'h4);
        chk(32'(dt[2] - dt[3]), 32'h4);
    endtask
    task automatic t_bclr;
        w(OFF_BANK, 32'h2);
        w(OFF_FADDR, 32'h245);
        w(OFF_FDATA, 32'hc7);
        w(OFF_STATUS, 32'h15);
        run(16'h9f45, 32'h2);
        rc(OFF_FDATA, 32'h47);
        rc(OFF_STATUS, 32'h15);
        w(OFF_FADDR, 32'h010);
        w(OFF_FDATA, 32'hff);
        run(16'h9010, 32'h2);
        rc(OFF_FDATA, 32'hfe);
    endtask
    // Unknown opcode: one-cycle no-op that flags itself
    task automatic t_illegal;
        w(OFF_PC, 32'h0200);
        run(16'h0123, 32'h2);
        rc(OFF_EXEC, 32'h12);
        rc(OFF_PC, 32'h0202);
        rc(OFF_OPCODE, 32'h0123);
        w(OFF_EXEC, 32'h2);
        rc(OFF_EXEC, 32'h10);
    endtask
    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0] r;
        m.rd(8'h20, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        m.wr(8'h24, 32'hffffffff, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_and();
        t_branch();
        t_bclr();
        t_illegal();
        t_unmapped();
        final_report();
    end
endmodule
bind abx_exec abx_exec_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
